// File: inc/sscp_consts.vh
// Constants for the serial stepper command parser
`ifndef SSCP_CONSTS_VH
`define SSCP_CONSTS_VH

// Clock and silence timeout
`define SSCP_CLK_HZ 25000000
`define SSCP_SILENCE_MS 3000

// Opcodes
`define SSCP_OP_IDENT 8'h03
`define SSCP_OP_KEEPALIVE 8'h04
`define SSCP_OP_CHIP_OPERATE 8'h41
`define SSCP_OP_DRV_RESET 8'h43
`define SSCP_OP_CUR_LIMIT 8'h44
`define SSCP_OP_OUT_VOLT 8'h45
`define SSCP_OP_STEP_ANGLE 8'h46
`define SSCP_OP_ROT_ANGLE 8'h51
`define SSCP_OP_ROT_TIME 8'h52
`define SSCP_OP_ROT_STEPS 8'h53
`define SSCP_OP_STOP_HOLD 8'h54
`define SSCP_OP_STOP_OFF 8'h55
`define SSCP_OP_EFFICIENCY 8'h61
`define SSCP_OP_REF_READ 8'h64
`define SSCP_OP_STATUS_READ 8'h65
`define SSCP_OP_ERR_CLEAR 8'h68

// Message lengths in bytes, opcode included
`define SSCP_LEN_1 4'h1
`define SSCP_LEN_2 4'h2
`define SSCP_LEN_3 4'h3
`define SSCP_LEN_4 4'h4
`define SSCP_LEN_7 4'h7
`define SSCP_LEN_9 4'h9

// Field limits
`define SSCP_SEL_MAX 8'h01
`define SSCP_VSUP_MIN 16'h005a
`define SSCP_VSUP_MAX 16'h0140
`define SSCP_ISUP_MAX 16'h0064
`define SSCP_IRATED_MIN 16'h0001
`define SSCP_IRATED_MAX 16'h0019
`define SSCP_RWIND_MIN 16'h0001
`define SSCP_RWIND_MAX 16'h1388
`define SSCP_VOUT_MAX 16'h0110
`define SSCP_ANGLE_MIN 16'h0001
`define SSCP_ANGLE_MAX 16'h8ca0
`define SSCP_FREQ_MAX 16'h0960
`define SSCP_ROT_ANG_MAX 32'h63ffff9c
`define SSCP_ROT_STEP_MAX 32'h00ffffff
`define SSCP_DIR_MAX 8'h01
`define SSCP_EXC_MAX 8'h03
`define SSCP_EFF_MAX 8'h01
`define SSCP_MARGIN_MAX 8'h02
`define SSCP_BOOST_MAX 8'h03

// Register offsets
`define SSCP_REG_CTRL 4'h0
`define SSCP_REG_STATUS 4'h4
`define SSCP_REG_COUNTS 4'h8

// Register fields and reset values
`define SSCP_CTRL_PARSE_EN 0
`define SSCP_CTRL_FAILSAFE_EN 1
`define SSCP_CTRL_RESET 2'h3
`define SSCP_STAT_TRIPPED 1

// Identity reply
`define SSCP_ID_BYTES 2'h3

// AXI responses
`define SSCP_RESP_OKAY 2'h0
`define SSCP_RESP_SLVERR 2'h2

`endif

// File: design/sscp_watchdog.v
// Link silence watchdog for the serial stepper command parser
`timescale 1ns/10ps
`include "sscp_consts.vh"

module sscp_watchdog #(
    parameter [31:0] SILENCE_CYCLES = 32'd75000000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire enable,
    input wire kick,
    // Status
    output reg trip_reg,
    output reg alive_reg
);

    reg [31:0] count_reg;

    // Armed only after the first byte, so power-up does not trip
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 32'h0;
            trip_reg <= 1'b0;
            alive_reg <= 1'b0;
        end else begin
            trip_reg <= 1'b0;
            if (kick) begin
                count_reg <= 32'h0;
                alive_reg <= 1'b1;
            end else if (alive_reg) begin
                if (count_reg >= SILENCE_CYCLES - 32'h1) begin
                    trip_reg <= enable;
                    alive_reg <= 1'b0;
                    count_reg <= 32'h0;
                end else begin
                    count_reg <= count_reg + 32'h1;
                end
            end
        end
    end

endmodule

// File: design/sscp_parser.v
// Serial stepper command parser with AXI4-Lite status registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "sscp_consts.vh"

module sscp_parser #(
    parameter [31:0] SILENCE_CYCLES = `SSCP_SILENCE_MS * (`SSCP_CLK_HZ / 1000),
    parameter [7:0] ID_DRIVER = 8'h5a,
    parameter [7:0] ID_VERSION = 8'h01
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Received serial bytes
    input wire rx_valid,
    input wire [7:0] rx_data,
    // Reply bytes
    output wire tx_valid,
    output reg [7:0] tx_data_reg,
    input wire tx_ready,
    // Parsed command
    output reg cmd_valid_reg,
    output reg [7:0] cmd_opcode_reg,
    output reg [63:0] cmd_payload_reg,
    // Motor control actions
    output reg stop_hold_reg,
    output reg stop_off_reg,
    output reg err_clear_reg,
    output reg chip_operate_reg,
    output reg driver_reset_reg,
    // AXI4-Lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam [1:0] ST_OP = 2'b01;
    localparam [1:0] ST_PAY = 2'b10;

    // Zero marks an opcode outside the command set
    function [3:0] msg_len;
        input [7:0] op;
        begin
            case (op)
                `SSCP_OP_IDENT, `SSCP_OP_KEEPALIVE, `SSCP_OP_STOP_HOLD,
                `SSCP_OP_STOP_OFF, `SSCP_OP_STATUS_READ, `SSCP_OP_ERR_CLEAR:
                    msg_len = `SSCP_LEN_1;
                `SSCP_OP_CHIP_OPERATE, `SSCP_OP_DRV_RESET, `SSCP_OP_REF_READ:
                    msg_len = `SSCP_LEN_2;
                `SSCP_OP_OUT_VOLT, `SSCP_OP_STEP_ANGLE:
                    msg_len = `SSCP_LEN_3;
                `SSCP_OP_EFFICIENCY:
                    msg_len = `SSCP_LEN_4;
                `SSCP_OP_ROT_TIME:
                    msg_len = `SSCP_LEN_7;
                `SSCP_OP_CUR_LIMIT, `SSCP_OP_ROT_ANGLE, `SSCP_OP_ROT_STEPS:
                    msg_len = `SSCP_LEN_9;
                default:
                    msg_len = 4'h0;
            endcase
        end
    endfunction

    function [15:0] le16;
        input [7:0] lo;
        input [7:0] hi;
        begin
            le16 = {hi, lo};
        end
    endfunction

    reg [1:0] state_reg;
    reg [7:0] op_reg;
    reg [3:0] len_reg;
    reg [3:0] cnt_reg;
    reg [7:0] pay_mem [0:7];
    reg done_reg;
    reg [7:0] done_op_reg;
    reg [1:0] ctrl_reg;
    reg tripped_reg;
    reg [15:0] accept_cnt_reg;
    reg [15:0] discard_cnt_reg;
    reg [1:0] tx_idx_reg;
    reg tx_busy_reg;
    reg aw_hold_reg;
    reg [3:0] aw_addr_reg;
    reg w_hold_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg fields_ok;
    wire [63:0] pay_flat;
    wire [3:0] first_len;
    wire byte_in;
    wire wd_trip;
    wire wd_alive;
    wire wr_fire;
    wire stat_clear;

    assign byte_in = rx_valid & ctrl_reg[`SSCP_CTRL_PARSE_EN];
    assign first_len = msg_len(rx_data);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flat
            assign pay_flat[gi*8 +: 8] = pay_mem[gi];
        end
    endgenerate

    sscp_watchdog #(
        .SILENCE_CYCLES(SILENCE_CYCLES)
    ) u_watchdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ctrl_reg[`SSCP_CTRL_FAILSAFE_EN]),
        .kick(byte_in),
        .trip_reg(wd_trip),
        .alive_reg(wd_alive)
    );

    // Framing: the opcode fixes the message length
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_OP;
            op_reg <= 8'h0;
            len_reg <= 4'h0;
            cnt_reg <= 4'h0;
            done_reg <= 1'b0;
            done_op_reg <= 8'h0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_OP: begin
                    if (byte_in) begin
                        op_reg <= rx_data;
                        len_reg <= first_len;
                        cnt_reg <= 4'h1;
                        if (first_len == `SSCP_LEN_1) begin
                            done_reg <= 1'b1;
                            done_op_reg <= rx_data;
                        end else if (first_len != 4'h0) begin
                            state_reg <= ST_PAY;
                        end
                    end
                end
                ST_PAY: begin
                    if (byte_in) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg + 4'h1 == len_reg) begin
                            done_reg <= 1'b1;
                            done_op_reg <= op_reg;
                            state_reg <= ST_OP;
                        end
                    end
                end
                default:
                    state_reg <= ST_OP;
            endcase
        end
    end

    // Payload bytes kept in arrival order, low byte first
    always @(posedge aclk) begin
        if (state_reg == ST_PAY && byte_in) begin
            pay_mem[cnt_reg[2:0] - 3'h1] <= rx_data;
        end
    end

    // Range checks on the completed message
    always @* begin
        fields_ok = 1'b1;
        case (done_op_reg)
            `SSCP_OP_CHIP_OPERATE, `SSCP_OP_DRV_RESET:
                fields_ok = pay_mem[0] <= `SSCP_SEL_MAX;
            `SSCP_OP_CUR_LIMIT:
                fields_ok = le16(pay_mem[0], pay_mem[1]) >= `SSCP_VSUP_MIN
                    && le16(pay_mem[0], pay_mem[1]) <= `SSCP_VSUP_MAX
                    && le16(pay_mem[2], pay_mem[3]) <= `SSCP_ISUP_MAX
                    && le16(pay_mem[4], pay_mem[5]) >= `SSCP_IRATED_MIN
                    && le16(pay_mem[4], pay_mem[5]) <= `SSCP_IRATED_MAX
                    && le16(pay_mem[6], pay_mem[7]) >= `SSCP_RWIND_MIN
                    && le16(pay_mem[6], pay_mem[7]) <= `SSCP_RWIND_MAX;
            `SSCP_OP_OUT_VOLT:
                fields_ok = le16(pay_mem[0], pay_mem[1]) <= `SSCP_VOUT_MAX;
            `SSCP_OP_STEP_ANGLE:
                fields_ok = le16(pay_mem[0], pay_mem[1]) >= `SSCP_ANGLE_MIN
                    && le16(pay_mem[0], pay_mem[1]) <= `SSCP_ANGLE_MAX;
            `SSCP_OP_ROT_ANGLE, `SSCP_OP_ROT_STEPS:
                fields_ok = le16(pay_mem[0], pay_mem[1]) <= `SSCP_FREQ_MAX
                    && pay_mem[6] <= `SSCP_DIR_MAX
                    && pay_mem[7] <= `SSCP_EXC_MAX
                    && {pay_mem[5], pay_mem[4], pay_mem[3], pay_mem[2]}
                    <= ((done_op_reg == `SSCP_OP_ROT_ANGLE) ?
                        `SSCP_ROT_ANG_MAX : `SSCP_ROT_STEP_MAX);
            `SSCP_OP_ROT_TIME:
                fields_ok = le16(pay_mem[0], pay_mem[1]) <= `SSCP_FREQ_MAX
                    && pay_mem[4] <= `SSCP_DIR_MAX
                    && pay_mem[5] <= `SSCP_EXC_MAX;
            `SSCP_OP_EFFICIENCY:
                fields_ok = pay_mem[0] <= `SSCP_EFF_MAX
                    && pay_mem[1] <= `SSCP_MARGIN_MAX
                    && pay_mem[2] <= `SSCP_BOOST_MAX;
            default:
                fields_ok = 1'b1;
        endcase
    end

    // Command issue and motor actions
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_valid_reg <= 1'b0;
            cmd_opcode_reg <= 8'h0;
            cmd_payload_reg <= 64'h0;
            stop_hold_reg <= 1'b0;
            stop_off_reg <= 1'b0;
            err_clear_reg <= 1'b0;
            chip_operate_reg <= 1'b0;
            driver_reset_reg <= 1'b0;
            accept_cnt_reg <= 16'h0;
            discard_cnt_reg <= 16'h0;
        end else begin
            cmd_valid_reg <= 1'b0;
            stop_hold_reg <= wd_trip;
            stop_off_reg <= 1'b0;
            err_clear_reg <= 1'b0;
            if (done_reg && fields_ok) begin
                // every legal message is strobed out
                cmd_valid_reg <= 1'b1;
                cmd_opcode_reg <= done_op_reg;
                cmd_payload_reg <= pay_flat;
                accept_cnt_reg <= accept_cnt_reg + 16'h1;
                case (done_op_reg)
                    `SSCP_OP_STOP_HOLD: stop_hold_reg <= 1'b1;
                    `SSCP_OP_STOP_OFF: stop_off_reg <= 1'b1;
                    `SSCP_OP_ERR_CLEAR: err_clear_reg <= 1'b1;
                    `SSCP_OP_CHIP_OPERATE: chip_operate_reg <= pay_mem[0][0];
                    `SSCP_OP_DRV_RESET: driver_reset_reg <= pay_mem[0][0];
                    default: cmd_valid_reg <= 1'b1;
                endcase
            end
            // discard; a bad end and a bad opcode may share a cycle
            discard_cnt_reg <= discard_cnt_reg + {15'h0, done_reg && !fields_ok}
                + {15'h0, state_reg == ST_OP && byte_in && first_len == 4'h0};
        end
    end

    // Identity reply: opcode echo, driver code, library version
    assign tx_valid = tx_busy_reg;

    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_busy_reg <= 1'b0;
            tx_idx_reg <= 2'h0;
            tx_data_reg <= 8'h0;
        end else if (!tx_busy_reg) begin
            if (done_reg && done_op_reg == `SSCP_OP_IDENT) begin
                tx_busy_reg <= 1'b1;
                tx_idx_reg <= 2'h1;
                tx_data_reg <= `SSCP_OP_IDENT;
            end
        end else if (tx_ready) begin
            tx_idx_reg <= tx_idx_reg + 2'h1;
            tx_data_reg <= (tx_idx_reg == 2'h1) ? ID_DRIVER : ID_VERSION;
            if (tx_idx_reg == `SSCP_ID_BYTES) begin
                tx_busy_reg <= 1'b0;
            end
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign stat_clear = wr_fire && aw_addr_reg == `SSCP_REG_STATUS
        && w_strb_reg[0] && w_data_reg[`SSCP_STAT_TRIPPED];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_hold_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSCP_RESP_OKAY;
            ctrl_reg <= `SSCP_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SSCP_RESP_OKAY;
                if (aw_addr_reg == `SSCP_REG_CTRL) begin
                    if (w_strb_reg[0]) begin
                        ctrl_reg <= w_data_reg[1:0];
                    end
                end else if (aw_addr_reg != `SSCP_REG_STATUS
                        && aw_addr_reg != `SSCP_REG_COUNTS) begin
                    s_axi_bresp <= `SSCP_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Trip flag: a new trip in the clearing cycle is kept
    always @(posedge aclk) begin
        if (!aresetn) begin
            tripped_reg <= 1'b0;
        end else if (wd_trip) begin
            tripped_reg <= 1'b1;
        end else if (stat_clear) begin
            tripped_reg <= 1'b0;
        end
    end

    // AXI4-Lite read side: answer one cycle after the address
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SSCP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SSCP_RESP_OKAY;
            case (s_axi_araddr)
                `SSCP_REG_CTRL: s_axi_rdata <= {30'h0, ctrl_reg};
                `SSCP_REG_STATUS:
                    s_axi_rdata <= {16'h0, op_reg, 4'h0, state_reg == ST_PAY,
                        wd_alive, tripped_reg, tx_busy_reg};
                `SSCP_REG_COUNTS:
                    s_axi_rdata <= {discard_cnt_reg, accept_cnt_reg};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `SSCP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// File: dv/sscp_host.sv
// Host side model: sends command bytes, takes reply bytes
`timescale 1ns/10ps
module sscp_host (
    // Clock
    input wire aclk,
    // Command bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    // Reply bytes
    input wire tx_valid,
    input wire [7:0] tx_data_reg,
    output logic tx_ready
);
    logic [7:0] replies[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
    end
    task automatic send(input logic [7:0] s[$]);
        foreach (s[i]) begin
            rx_valid <= 1'b1;
            rx_data <= s[i];
            @(posedge aclk);
        end
        rx_valid <= 1'b0;
        // Idle data shows the inverse, so a stale byte is never mistaken for a new one
        rx_data <= ~s[s.size() - 1];
    endtask
    // Slow or prompt reply sink
    always @(posedge aclk) begin
        if (tx_valid && tx_ready)
            replies.push_back(tx_data_reg);
        tx_ready <= 1'($urandom);
    end
endmodule

// File: dv/sscp_parser_assertions.sv
// Assertions for the serial stepper command parser
`timescale 1ns/10ps
module sscp_parser_assertions #(
    parameter [31:0] SILENCE_CYCLES = 32'd75000000
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Serial side
    input wire rx_valid,
    input wire tx_valid,
    input wire [7:0] tx_data_reg,
    input wire tx_ready,
    // Command side
    input wire cmd_valid_reg,
    input wire [7:0] cmd_opcode_reg,
    input wire [63:0] cmd_payload_reg,
    input wire stop_hold_reg,
    input wire stop_off_reg,
    input wire err_clear_reg,
    input wire chip_operate_reg,
    input wire driver_reset_reg
);
    logic [31:0] quiet_reg;
    wire [8:0] cmd_seen = {cmd_valid_reg, cmd_opcode_reg};
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Saturates so a long idle never wraps back into the window
    always @(posedge aclk) begin
        if (!aresetn || rx_valid)
            quiet_reg <= 32'h0;
        else if (quiet_reg != 32'hffffffff)
            quiet_reg <= quiet_reg + 32'h1;
    end
    sequence s_stalled;
        tx_valid && !tx_ready;
    endsequence
    sequence s_cmd(logic [7:0] op);
        cmd_valid_reg && cmd_opcode_reg == op;
    endsequence
    a_reply_held: assert property (s_stalled |=> tx_valid && $stable(tx_data_reg))
        else $error("reply byte moved while stalled");
    a_cmd_after_byte: assert property (cmd_valid_reg |-> $past(rx_valid, 2))
        else $error("command without a closing byte");
    a_hold_stop: assert property (s_cmd(8'h54) |-> stop_hold_reg)
        else $error("hold stop missing");
    a_off_stop: assert property (stop_off_reg == (cmd_seen == 9'h155))
        else $error("outputs off stop wrong");
    a_clear_errors: assert property (err_clear_reg == (cmd_seen == 9'h168))
        else $error("error clear wrong");
    a_chip_select: assert property (s_cmd(8'h41) |->
        cmd_payload_reg[7:1] == 7'h0 && chip_operate_reg == cmd_payload_reg[0])
        else $error("operate select wrong");
    a_reset_select: assert property (s_cmd(8'h43) |->
        cmd_payload_reg[7:1] == 7'h0 && driver_reset_reg == cmd_payload_reg[0])
        else $error("reset select wrong");
    a_vout_range: assert property (s_cmd(8'h45) |-> cmd_payload_reg[15:0] <= 16'h0110)
        else $error("output voltage too high");
    a_silence_stop: assert property (stop_hold_reg && cmd_seen != 9'h154
        |-> quiet_reg >= SILENCE_CYCLES - 32'd2 && quiet_reg <= SILENCE_CYCLES + 32'd3)
        else $error("failsafe stop mistimed");
endmodule
bind sscp_parser sscp_parser_assertions #(.SILENCE_CYCLES(SILENCE_CYCLES))
    u_sscp_parser_assertions (
    .aclk(aclk), .aresetn(aresetn), .rx_valid(rx_valid), .tx_valid(tx_valid),
    .tx_data_reg(tx_data_reg), .tx_ready(tx_ready), .cmd_valid_reg(cmd_valid_reg),
    .cmd_opcode_reg(cmd_opcode_reg), .cmd_payload_reg(cmd_payload_reg),
    .stop_hold_reg(stop_hold_reg), .stop_off_reg(stop_off_reg), .err_clear_reg(err_clear_reg),
    .chip_operate_reg(chip_operate_reg), .driver_reset_reg(driver_reset_reg));

// File: dv/test_stepper_serial_command_parser.sv
// Testbench for the serial stepper command parser
`timescale 1ns/10ps
module test_stepper_serial_command_parser;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rv;
    logic [1:0] rr;
    logic [7:0] op, s[$];
    logic [71:0] exp_q[$];
    int len_q[$];
    int fails, samples_checked, acc, disc, trips;
    logic [7:0] ops[15] = '{8'h04, 8'h41, 8'h43, 8'h44, 8'h45, 8'h46, 8'h51, 8'h52, 8'h53,
        8'h54, 8'h55, 8'h61, 8'h64, 8'h65, 8'h68};
    wire rx_valid, tx_valid, tx_ready, cmd_valid_reg, stop_hold_reg, stop_off_reg, err_clear_reg;
    wire chip_operate_reg, driver_reset_reg, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid;
    wire [7:0] rx_data, tx_data_reg, cmd_opcode_reg;
    wire [63:0] cmd_payload_reg;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;

    // Identity values are arbitrary
    sscp_parser #(.SILENCE_CYCLES(200), .ID_DRIVER(8'ha7), .ID_VERSION(8'h3c)) u_sscp_parser (
        .aclk, .aresetn, .rx_valid, .rx_data, .tx_valid, .tx_data_reg, .tx_ready,
        .cmd_valid_reg, .cmd_opcode_reg, .cmd_payload_reg, .stop_hold_reg, .stop_off_reg,
        .err_clear_reg, .chip_operate_reg, .driver_reset_reg, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    sscp_host u_sscp_host (.aclk, .rx_valid, .rx_data, .tx_valid, .tx_data_reg, .tx_ready);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [63:0] sn, input logic [63:0] ex);
        samples_checked++;
        if (sn !== ex) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    task automatic results;
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic int mlen(input logic [7:0] o);
        case (o)
            8'h03, 8'h04, 8'h54, 8'h55, 8'h65, 8'h68: return 1;
            8'h41, 8'h43, 8'h64: return 2;
            8'h45, 8'h46: return 3;
            8'h61: return 4;
            8'h52: return 7;
            8'h44, 8'h51, 8'h53: return 9;
            default: return 0;
        endcase
    endfunction

    function automatic bit ok(input logic [7:0] m[9]);
        logic [15:0] w1, w3, w5, w7;
        logic [31:0] g;
        w1 = {m[2], m[1]};
        w3 = {m[4], m[3]};
        w5 = {m[6], m[5]};
        w7 = {m[8], m[7]};
        g = {m[6], m[5], m[4], m[3]};
        case (m[0])
            8'h41, 8'h43: return m[1] <= 8'h01;
            8'h44: return w1 >= 16'h005a && w1 <= 16'h0140 && w3 <= 16'h0064 && w5 >= 16'h0001
                && w5 <= 16'h0019 && w7 >= 16'h0001 && w7 <= 16'h1388;
            8'h45: return w1 <= 16'h0110;
            8'h46: return w1 >= 16'h0001 && w1 <= 16'h8ca0;
            8'h51, 8'h53: return w1 <= 16'h0960 && m[7] <= 8'h01 && m[8] <= 8'h03
                && g <= ((m[0] == 8'h51) ? 32'h63ffff9c : 32'h00ffffff);
            8'h52: return w1 <= 16'h0960 && m[5] <= 8'h01 && m[6] <= 8'h03;
            8'h61: return m[1] <= 8'h01 && m[2] <= 8'h02 && m[3] <= 8'h03;
            default: return 1'b1;
        endcase
    endfunction

    // Model parses the byte stream, then the host sends it back to back
    task automatic run(input logic [7:0] q[$]);
        logic [7:0] m[9];
        int i, n;
        i = 0;
        while (i < q.size()) begin
            n = mlen(q[i]);
            m = '{default: 8'h00};
            for (int k = 0; k < n; k++)
                m[k] = q[i + k];
            if (n > 0 && ok(m)) begin
                exp_q.push_back({m[0], m[8], m[7], m[6], m[5], m[4], m[3], m[2], m[1]});
                len_q.push_back(n);
                acc++;
            end else
                disc++;
            i += (n > 0) ? n : 1;
        end
        u_sscp_host.send(q);
        @(posedge aclk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta)
                s_axi_arvalid <= 1'b0;
        end
    endtask

    always @(posedge aclk) begin
        logic [71:0] e;
        logic [63:0] mk;
        if (stop_hold_reg === 1'b1 && !(cmd_valid_reg === 1'b1 && cmd_opcode_reg === 8'h54))
            trips++;
        if (cmd_valid_reg === 1'b1) begin
            if (exp_q.size() == 0)
                chk("cmd_valid", 64'h1, 64'h0);
            else begin
                e = exp_q.pop_front();
                mk = (64'h1 << (8 * (len_q.pop_front() - 1))) - 64'h1;
                chk("opcode", cmd_opcode_reg, e[71:64]);
                chk("payload", cmd_payload_reg & mk, e[63:0] & mk);
            end
        end
    end

    initial begin
        #(40 * 20000);
        fails++;
        results();
    end

    initial begin
        void'($urandom(32'hc632));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(4'h0, rv, rr);
        chk("ctrl", {rr, rv}, {2'h0, 32'h3});
        rd(4'hc, rv, rr);
        chk("unmapped read", {rr, rv}, {2'h2, 32'h0});
        wr(4'hc, 32'h1, rr);
        chk("unmapped write", rr, 2'h2);
        run('{8'h03});
        repeat (40) @(posedge aclk);
        chk("reply count", u_sscp_host.replies.size(), 3);
        chk("reply", {u_sscp_host.replies[0], u_sscp_host.replies[1], u_sscp_host.replies[2]},
            {8'h03, 8'ha7, 8'h3c});
        run('{8'h41, 8'h01, 8'h41, 8'h02, 8'h43, 8'h01, 8'h54, 8'h55, 8'h68, 8'h9e, 8'h44,
            8'h5a, 8'h00, 8'h64, 8'h00, 8'h19, 8'h00, 8'h88, 8'h13, 8'h44, 8'h59, 8'h00, 8'h00,
            8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h45, 8'h10, 8'h01, 8'h45, 8'h11, 8'h01, 8'h46,
            8'ha0, 8'h8c, 8'h53, 8'h60, 8'h09, 8'hff, 8'hff, 8'hff, 8'h00, 8'h01, 8'h03, 8'h61,
            8'h01, 8'h03, 8'h00, 8'h65, 8'h64, 8'h07, 8'h43, 8'h00});
        for (int j = 0; j < 150; j++) begin
            op = ($urandom % 6 == 0) ? 8'($urandom) : ops[$urandom % 15];
            if (op == 8'h03)
                op = 8'h04;
            s = '{op};
            for (int k = 1; k < mlen(op); k++)
                s.push_back(($urandom % 2) ? 8'($urandom % 4) : 8'($urandom));
            run(s);
        end
        trips = 0;
        repeat (3) begin
            repeat (150) @(posedge aclk);
            run('{8'h04});
        end
        chk("early stop", trips, 0);
        repeat (260) @(posedge aclk);
        chk("failsafe stop", trips, 1);
        rd(4'h4, rv, rr);
        chk("tripped flag", rv[1], 1'b1);
        wr(4'h4, 32'h2, rr);
        rd(4'h4, rv, rr);
        chk("tripped clear", rv[1], 1'b0);
        rd(4'h8, rv, rr);
        chk("counts", rv, {disc[15:0], acc[15:0]});
        chk("missing commands", exp_q.size(), 0);
        results();
    end
endmodule
